//--- sim/rtc_line_src.sv
// horizontal line timing source standing in for the raster logic beside the block
module rtc_line_src #(
    parameter int LINE_CYC = 16             // clock cycles per horizontal line
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // pacing: doubles the line length when high
    input  wire logic slow,
    // line timing
    output logic      char_en,
    output logic      hretrace
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt_r;                               // position within the line
    initial begin
        cnt_r = 0;
        char_en = 1'b0;
        hretrace = 1'b0;
    end
    //------------------------------------------------------------------
    // line counter, moved just after the edge like any other driver
    //------------------------------------------------------------------
    // retrace spans three cycles so an edge detector cannot miss it
    always @(posedge mclk) begin
        #1;
        if (!rst_n || cnt_r >= (slow ? 2 * LINE_CYC : LINE_CYC) - 1)
            cnt_r = 0;
        else
            cnt_r = cnt_r + 1;
        hretrace = (cnt_r < 3);
        char_en = cnt_r[0];              // character slot every second cycle
    end
endmodule

//--- sim/test_rtc_vtiming.sv
// self-checking bench for the vertical timing, cursor and frame interrupt block
module test_rtc_vtiming;
    timeunit 1ns;
    timeprecision 1ps;
    import rtc_pkg::*;
    //------------------------------------------------------------------
    // stimulus, observed outputs and bookkeeping
    //------------------------------------------------------------------
    logic         mclk = 1'b0;            // 200 MHz
    logic         rst_n = 1'b0;           // sync, active low
    rtc_port_type io_sel = RTC_PORT_NONE;
    logic         io_wr = 1'b0;
    logic         io_rd = 1'b0;
    logic [7:0]   io_wdata = 8'h00;
    logic [9:0]   vdisp_end = 10'h010;    // display end line
    logic         enhanced_mode = 1'b0;
    logic         slow = 1'b0;
    logic         chk = 1'b0;             // a result is due at the next edge
    logic [3:0]   chk_sel = 4'h0;         // which output holds it
    logic [7:0]   io_rdata, cursor_fg, cursor_bg, d;
    logic         vsync, frame_irq, char_en, hretrace, cursor;
    logic [4:0]   row_scan;
    logic [9:0]   line_count, vbb_hi, spl_hi;
    logic [9:0]   max_seen = 10'h000;     // highest line seen in a frame
    logic [15:0]  row_addr;
    logic [1:0]   pan_delay;
    logic [2:0]   refresh_per_line;
    logic [15:0]  exp_q[$];               // expected results, oldest first
    int           bad_count = 0;
    int           cmp_count = 0;
    int           i;
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) if (rst_n && line_count > max_seen) max_seen <= line_count;
    rtc_vtiming rtc_vtiming_i (.mclk(mclk), .rst_n(rst_n), .io_sel(io_sel), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .char_en(char_en),
        .hretrace(hretrace), .vdisp_end(vdisp_end), .enhanced_mode(enhanced_mode),
        .vsync(vsync), .row_scan(row_scan), .line_count(line_count), .row_addr(row_addr),
        .pan_delay(pan_delay), .cursor(cursor), .cursor_fg(cursor_fg), .cursor_bg(cursor_bg),
        .refresh_per_line(refresh_per_line), .frame_irq(frame_irq),
        .vblank_begin_hi(vbb_hi), .split_line_hi(spl_hi));
    rtc_line_src rtc_line_src_i (.mclk(mclk), .rst_n(rst_n), .slow(slow),
        .char_en(char_en), .hretrace(hretrace));
    //------------------------------------------------------------------
    // result watcher: values are taken before the edge's own updates land
    //------------------------------------------------------------------
    function automatic logic [15:0] obs(input logic [3:0] s);
        case (s)
            4'h0: return {8'h00, io_rdata};
            4'h1: return {15'h0000, vsync};
            4'h2: return {11'h000, row_scan};
            4'h3: return {15'h0000, cursor};
            4'h4: return row_addr;
            4'h5: return {14'h0000, pan_delay};
            4'h6: return {cursor_fg, cursor_bg};
            4'h7: return {13'h0000, refresh_per_line};
            4'h8: return {15'h0000, frame_irq};
            4'h9: return {vbb_hi[9:8], spl_hi[9:8], 2'h0, vbb_hi[7:0] | spl_hi[7:0], 2'h0};
            default: return {6'h00, max_seen};
        endcase
    endfunction
    always @(posedge mclk) begin
        if (chk && exp_q.size() > 0) begin
            cmp_count++;
            if (obs(chk_sel) !== exp_q[0]) begin
                bad_count++;
                $display("MISMATCH t=%0t sel %0d got %h exp %h", $time, chk_sel,
                         obs(chk_sel), exp_q[0]);
            end
            void'(exp_q.pop_front());
        end
    end
    //------------------------------------------------------------------
    // driver tasks, all entered one small delay after an edge
    //------------------------------------------------------------------
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic expect_val(input logic [3:0] s, input logic [15:0] v);
        exp_q.push_back(v);
        chk_sel = s;
        chk = 1'b1;
        @(posedge mclk) #1;
        chk = 1'b0;
    endtask
    // index first, then the data port in the next cycle; an idle cycle follows each access
    task automatic set_index(input logic [7:0] idx);
        io_sel = RTC_PORT_INDEX;
        io_wr = 1'b1;
        io_wdata = idx;
        @(posedge mclk) #1;
        io_wr = 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        set_index(idx);
        io_sel = RTC_PORT_DATA;
        io_wr = 1'b1;
        io_wdata = v;
        @(posedge mclk) #1;
        io_wr = 1'b0;
        io_sel = RTC_PORT_NONE;
        @(posedge mclk) #1;
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] v);
        set_index(idx);
        io_sel = RTC_PORT_DATA;
        io_rd = 1'b1;
        expect_val(4'h0, {8'h00, v});
        io_rd = 1'b0;
        io_sel = RTC_PORT_NONE;
        @(posedge mclk) #1;
    endtask
    task automatic wait_line(input logic [9:0] n);
        int k;
        k = 0;
        while (line_count !== n && k < 20000) begin
            @(posedge mclk) #1;
            k++;
        end
        if (k >= 20000) begin
            bad_count++;
            $display("MISMATCH t=%0t line %0d never reached", $time, n);
            close_out();
        end
    endtask
    //------------------------------------------------------------------
    // main sequence
    //------------------------------------------------------------------
    initial begin
        void'($urandom(32'h7d3bfa28));
        repeat (8) @(posedge mclk);
        #1 rst_n = 1'b1;
        for (i = 0; i <= 18; i++) rd(i[7:0], 8'h00);
        expect_val(4'h7, 16'h0003);
        for (i = 6; i <= 16; i++) begin
            d = 8'($urandom());
            wr(i[7:0], d);
            rd(i[7:0], d);
        end
        wr(8'h07, 8'h08);
        wr(8'h09, 8'h40);
        expect_val(4'h9, 16'h6000);
        wr(8'h08, 8'h40);
        expect_val(4'h5, 16'h0002);
        wr(8'h0e, 8'ha5);
        wr(8'h0f, 8'h3c);
        expect_val(4'h6, 16'h0000);
        enhanced_mode = 1'b1;
        expect_val(4'h6, 16'ha53c);
        enhanced_mode = 1'b0;
        wr(8'h11, 8'h40);
        expect_val(4'h7, 16'h0005);
        wr(8'h06, 8'h11);
        wr(8'h11, 8'hc0);
        wr(8'h06, 8'h77);
        rd(8'h06, 8'h11);
        wr(8'h07, 8'hff);
        rd(8'h07, 8'h18);
        wr(8'h11, 8'h00);
        // total 104h and sync start 102h both need the ninth bit
        wr(8'h06, 8'h04);
        wr(8'h07, 8'h05);
        wr(8'h10, 8'h02);
        wr(8'h08, 8'h01);
        wr(8'h09, 8'h02);
        wr(8'h0c, 8'h12);
        wr(8'h0d, 8'h34);
        wr(8'h11, 8'h15);
        wait_line(10'h000);
        for (i = 0; i < 2; i++) begin
            wait_line(10'h001);
            wait_line(10'h000);
        end
        wait_line(10'h002);
        expect_val(4'h2, 16'h0000);
        wait_line(10'h003);
        expect_val(4'h1, 16'h0000);
        max_seen = 10'h000;
        wait_line(10'h104);
        expect_val(4'h1, 16'h0001);
        wait_line(10'h000);
        expect_val(4'ha, 16'h0105);
        expect_val(4'h2, 16'h0001);
        expect_val(4'h4, 16'h1234);
        expect_val(4'h1, 16'h0000);
        // cursor on rows one and two at the origin address, no skew
        wr(8'h0a, 8'h00);
        wr(8'h0b, 8'h02);
        wr(8'h0e, 8'h12);
        wr(8'h0f, 8'h34);
        wait_line(10'h001);
        repeat (4) @(posedge mclk) #1;
        expect_val(4'h3, 16'h0001);
        wr(8'h0a, 8'h05);
        repeat (4) @(posedge mclk) #1;
        expect_val(4'h3, 16'h0000);
        slow = 1'b1;
        wait_line(10'h020);
        expect_val(4'h8, 16'h0001);
        wr(8'h11, 8'h05);
        expect_val(4'h8, 16'h0000);
        wr(8'h11, 8'h15);
        wait_line(10'h005);
        expect_val(4'h8, 16'h0000);
        wr(8'h11, 8'h35);
        wait_line(10'h020);
        expect_val(4'h8, 16'h0000);
        wr(8'h11, 8'h15);
        expect_val(4'h8, 16'h0001);
        close_out();
    end
endmodule

//--- src/rtc_consts.svh
// offsets, field positions and reset values of the vertical and cursor timing block
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH
`define RTC_IDX_VTOTAL      8'h06
`define RTC_IDX_OVFL        8'h07
`define RTC_IDX_PRESET      8'h08
`define RTC_IDX_ROWH        8'h09
`define RTC_IDX_CSTART      8'h0a
`define RTC_IDX_CEND        8'h0b
`define RTC_IDX_ORG_HI      8'h0c
`define RTC_IDX_ORG_LO      8'h0d
`define RTC_IDX_CUR_HI      8'h0e
`define RTC_IDX_CUR_LO      8'h0f
`define RTC_IDX_VSB         8'h10
`define RTC_IDX_VSE         8'h11
`define RTC_IDX_LOCK_LAST   8'h07
`define RTC_OVFL_SPLIT8_BIT 4
`define RTC_VSE_CLR_BIT     4
`define RTC_VSE_DIS_BIT     5
`define RTC_VSE_REF_BIT     6
`define RTC_VSE_LOCK_BIT    7
`define RTC_ROWH_DBL_BIT    7
`define RTC_CSTART_OFF_BIT  5
`define RTC_REG_RESET       8'h00
`define RTC_REF_FEW         3'h3
`define RTC_REF_MANY        3'h5
`endif

//--- src/rtc_pkg.sv
// types shared by the vertical and cursor timing block
package rtc_pkg;
    // i/o port select seen on the host side
    typedef enum logic [1:0] {
        RTC_PORT_NONE,
        RTC_PORT_INDEX,
        RTC_PORT_DATA
    } rtc_port_type;
    // vertical sync state
    typedef enum logic {
        RTC_VS_IDLE,
        RTC_VS_ACTIVE
    } rtc_vs_type;
endpackage

//--- src/rtc_vtiming.sv
// vertical timing, row scan, cursor and frame interrupt logic with indexed registers
//----------------------------------------------------------------------------
// Operation
// - ten-bit vertical total sets frame period
// - overflow register supplies bits eight and nine
// - row scan starts from preset each screen
// - row scan advances, wraps at maximum
// - character_pan_count delays display by characters
// - maximum scan line is rows minus one
// - row height register carries two bit nines
// - double scan repeats row and address
// - cursor start minus one, disable bit
// - cursor end; start above end hides
// - cursor skew delays zero to three
// - display origin fetched after vertical retrace
// - cursor address marks cursor location
// - enhanced mode: cursor bytes become colours
// - vsync starts at ten-bit line
// - vsync ends on low four bits
// - frame interrupt set at display end
// - write zero clears, one rearms interrupt
// - interrupt disable bit gates the output
// - refresh select three or five
// - lock protects indices zero to seven
// - index port first, then data port
//----------------------------------------------------------------------------
`include "rtc_consts.svh"

module rtc_vtiming #(
    parameter int ADDR_W = 16              // memory address width
) (
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    // host i/o port pair
    input  wire rtc_pkg::rtc_port_type io_sel,
    input  wire logic                 io_wr,
    input  wire logic                 io_rd,
    input  wire logic [7:0]           io_wdata,
    output logic      [7:0]           io_rdata,
    // timing inputs
    input  wire logic                 char_en,
    input  wire logic                 hretrace,
    input  wire logic [9:0]           vdisp_end,
    input  wire logic                 enhanced_mode,
    // display outputs
    output logic                      vsync,
    output logic      [4:0]           row_scan,
    output logic      [9:0]           line_count,
    output logic      [ADDR_W-1:0]    row_addr,
    output logic      [1:0]           pan_delay,
    output logic                      cursor,
    output logic      [7:0]           cursor_fg,
    output logic      [7:0]           cursor_bg,
    output logic      [2:0]           refresh_per_line,
    output logic                      frame_irq,
    // unused upper-bit views for outside comparators
    output logic      [9:0]           vblank_begin_hi,
    output logic      [9:0]           split_line_hi
);
    import rtc_pkg::*;

    //------------------------------------------------------------------------
    // register storage
    //------------------------------------------------------------------------
    logic [7:0] index_r;                   // index port latch
    logic [7:0] regs_r [6:17];             // indices 06h to 11h
    logic       irq_r;                     // frame interrupt flip-flop
    logic       hr_d_r;                    // horizontal retrace delayed
    logic       dbl_phase_r;               // second pass of a doubled line
    logic [3:0] cur_pipe_r;                // cursor skew chain
    rtc_vs_type vs_r;                      // vsync state

    // decode shared by write and read paths
    function automatic logic idx_mapped(input logic [7:0] i);
        idx_mapped = (i >= `RTC_IDX_VTOTAL) && (i <= `RTC_IDX_VSE);
    endfunction

    // lock check: whole protected range; the write path lets the split line bit eight through
    function automatic logic idx_locked(input logic [7:0] i, input logic lk);
        idx_locked = lk && (i <= `RTC_IDX_LOCK_LAST);
    endfunction

    //------------------------------------------------------------------------
    // field views
    //------------------------------------------------------------------------
    logic [9:0] vtotal;                    // full vertical total
    logic [9:0] vsb;                       // full vsync begin
    logic [4:0] max_scan;                  // rows per character minus one
    logic       hr_rise;                   // one pulse per scan line
    logic       lock;                      // write protect
    assign vtotal = {regs_r[7][5], regs_r[7][0], regs_r[6]};
    assign vsb    = {regs_r[7][7], regs_r[7][2], regs_r[16]};
    assign max_scan = regs_r[9][4:0];
    assign hr_rise  = hretrace && !hr_d_r;
    assign lock     = regs_r[17][`RTC_VSE_LOCK_BIT];
    assign vblank_begin_hi = {regs_r[9][5], regs_r[7][3], 8'h00};
    assign split_line_hi   = {regs_r[9][6], regs_r[7][4], 8'h00};

    //------------------------------------------------------------------------
    // host port: index then data
    //------------------------------------------------------------------------
    // index write latches the target register
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            index_r <= `RTC_REG_RESET;
        end else if (io_wr && io_sel == RTC_PORT_INDEX) begin
            index_r <= io_wdata;
        end
    end

    // data writes, filtered by the lock
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            for (int k = 6; k <= 17; k++) begin
                regs_r[k] <= `RTC_REG_RESET;
            end
        end else if (io_wr && io_sel == RTC_PORT_DATA && idx_mapped(index_r)) begin
            if (!idx_locked(index_r, lock)) begin
                regs_r[index_r[4:0]] <= io_wdata;
            end else if (index_r == `RTC_IDX_OVFL) begin
                // only the split line bit eight stays writable
                regs_r[7][`RTC_OVFL_SPLIT8_BIT] <= io_wdata[`RTC_OVFL_SPLIT8_BIT];
            end
        end
    end

    // read mux; reserved bits of some registers read as stored, unmapped as zero
    always_comb begin
        io_rdata = 8'h00;
        if (io_sel == RTC_PORT_INDEX) begin
            io_rdata = index_r;
        end else if (io_sel == RTC_PORT_DATA && idx_mapped(index_r)) begin
            io_rdata = regs_r[index_r[4:0]];
        end
    end

    //------------------------------------------------------------------------
    // vertical counters
    //------------------------------------------------------------------------
    // edge detect on horizontal retrace
    always_ff @(posedge mclk) begin
        if (!rst_n) hr_d_r <= 1'b0;
        else        hr_d_r <= hretrace;
    end

    logic frame_end;                       // last line of the frame
    assign frame_end = (line_count == vtotal + 10'h001);

    // line counter wraps after total plus two lines
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            line_count <= 10'h000;
        end else if (hr_rise) begin
            line_count <= frame_end ? 10'h000 : line_count + 10'h001;
        end
    end

    // row scan and doubling; vertical timing itself is untouched by doubling
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            row_scan    <= 5'h00;
            dbl_phase_r <= 1'b0;
            row_addr    <= '0;
        end else if (hr_rise) begin
            if (frame_end) begin
                row_scan    <= regs_r[8][4:0];
                dbl_phase_r <= 1'b0;
                row_addr    <= ADDR_W'({regs_r[12], regs_r[13]});
            end else if (regs_r[9][`RTC_ROWH_DBL_BIT] && !dbl_phase_r) begin
                dbl_phase_r <= 1'b1;
            end else begin
                dbl_phase_r <= 1'b0;
                row_scan    <= (row_scan == max_scan) ? 5'h00 : row_scan + 5'h01;
            end
        end
    end

    assign pan_delay = regs_r[8][6:5];

    //------------------------------------------------------------------------
    // vertical sync
    //------------------------------------------------------------------------
    // starts at the ten-bit line, ends on a four-bit match
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            vs_r <= RTC_VS_IDLE;
        end else begin
            case (vs_r)
                RTC_VS_IDLE: begin
                    if (line_count == vsb) vs_r <= RTC_VS_ACTIVE;
                end
                RTC_VS_ACTIVE: begin
                    if (line_count[3:0] == regs_r[17][3:0]) vs_r <= RTC_VS_IDLE;
                end
                default: vs_r <= RTC_VS_IDLE;
            endcase
        end
    end
    assign vsync = (vs_r == RTC_VS_ACTIVE);

    //------------------------------------------------------------------------
    // text cursor
    //------------------------------------------------------------------------
    logic [4:0] c_start;                   // first line minus one
    logic [4:0] c_end;                     // last line
    logic       cur_raw;                   // undelayed cursor
    assign c_start = regs_r[10][4:0];
    assign c_end   = regs_r[11][4:0];
    // start above end shows nothing; lines after start through end shown
    assign cur_raw = !regs_r[10][`RTC_CSTART_OFF_BIT] && (c_start <= c_end)
                     && (row_scan > c_start) && (row_scan <= c_end)
                     && (row_addr == ADDR_W'({regs_r[14], regs_r[15]}));

    // skew chain clocked on the character enable
    always_ff @(posedge mclk) begin
        if (!rst_n) cur_pipe_r <= 4'h0;
        else if (char_en) cur_pipe_r <= {cur_pipe_r[2:0], cur_raw};
    end
    assign cursor = cur_pipe_r[regs_r[11][6:5]];

    // enhanced mode reuses the cursor address bytes as colours
    assign cursor_fg = enhanced_mode ? regs_r[14] : 8'h00;
    assign cursor_bg = enhanced_mode ? regs_r[15] : 8'h00;

    //------------------------------------------------------------------------
    // frame interrupt and refresh select
    //------------------------------------------------------------------------
    // set at end of display while armed; clear bit four at zero holds it reset
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irq_r <= 1'b0;
        end else if (!regs_r[17][`RTC_VSE_CLR_BIT]) begin
            irq_r <= 1'b0;
        end else if (hr_rise && line_count == vdisp_end) begin
            irq_r <= 1'b1;
        end
    end
    assign frame_irq = irq_r && !regs_r[17][`RTC_VSE_DIS_BIT];
    assign refresh_per_line = regs_r[17][`RTC_VSE_REF_BIT] ? `RTC_REF_MANY
                                                           : `RTC_REF_FEW;

    //------------------------------------------------------------------------
    // checks
    //------------------------------------------------------------------------
    a_line_wrap: assert property (@(posedge mclk) disable iff (!rst_n)
        hr_rise && frame_end |=> line_count == 10'h000)
        else $error("line counter did not wrap");
    a_preset_load: assert property (@(posedge mclk) disable iff (!rst_n)
        hr_rise && frame_end |=> row_scan == $past(regs_r[8][4:0]))
        else $error("row scan not preset");
    a_irq_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        !regs_r[17][4] |=> !irq_r)
        else $error("interrupt not cleared");
    a_irq_mask: assert property (@(posedge mclk) disable iff (!rst_n)
        regs_r[17][5] |-> !frame_irq)
        else $error("disabled interrupt asserted");
    a_lock_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        io_wr && io_sel == RTC_PORT_DATA && lock && index_r == 8'h06 |=> $stable(regs_r[6]))
        else $error("locked write took effect");
    a_vs_start: assert property (@(posedge mclk) disable iff (!rst_n)
        vs_r == RTC_VS_IDLE && line_count == vsb |=> vsync)
        else $error("vsync did not start");
    a_cursor_off: assert property (@(posedge mclk) disable iff (!rst_n)
        regs_r[10][5] |-> !cur_raw)
        else $error("cursor shown while disabled");
    a_row_wrap: assert property (@(posedge mclk) disable iff (!rst_n)
        hr_rise && !frame_end && !regs_r[9][7] && row_scan == max_scan |=> row_scan == 5'h00)
        else $error("row scan did not wrap");
    a_irq_set: assert property (@(posedge mclk) disable iff (!rst_n)
        regs_r[17][4] && hr_rise && line_count == vdisp_end |=> irq_r)
        else $error("interrupt not set");

    //------------------------------------------------------------------------
    // multi-step checks built from named sequences, and two single-cycle cursor checks
    //------------------------------------------------------------------------
    // an ordinary line step, not the wrap at the end of the frame
    sequence s_line_step;
        hr_rise && !frame_end;
    endsequence

    // first pass of a doubled line
    sequence s_dbl_first;
        hr_rise && !frame_end && regs_r[9][`RTC_ROWH_DBL_BIT] && !dbl_phase_r;
    endsequence

    // the wrap line: preset and origin are reloaded here
    sequence s_frame_wrap;
        hr_rise && frame_end;
    endsequence

    // sync active and the low nibble has reached the end field
    sequence s_vs_end_match;
        vs_r == RTC_VS_ACTIVE && line_count[3:0] == regs_r[17][3:0];
    endsequence

    // unlocked data write to the vertical total register
    sequence s_open_write;
        io_wr && io_sel == RTC_PORT_DATA && !lock && index_r == `RTC_IDX_VTOTAL;
    endsequence

    // character slot with zero skew selected
    sequence s_char_noskew;
        char_en && regs_r[11][6:5] == 2'h0;
    endsequence

    // the counter must step by exactly one between wraps
    a_line_step: assert property (@(posedge mclk) disable iff (!rst_n)
        s_line_step |=> line_count == $past(line_count) + 10'h001)
        else $error("line counter skipped");

    // doubling keeps the row scan for one more line
    a_dbl_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        s_dbl_first |=> $stable(row_scan))
        else $error("doubled line not repeated");

    // origin is reloaded at every frame wrap
    a_origin_load: assert property (@(posedge mclk) disable iff (!rst_n)
        s_frame_wrap |=> row_addr == $past(ADDR_W'({regs_r[12], regs_r[13]})))
        else $error("display origin not loaded");

    // sync drops one cycle after the nibble match
    a_vs_end: assert property (@(posedge mclk) disable iff (!rst_n)
        s_vs_end_match |=> !vsync)
        else $error("vsync did not end");

    // an unlocked write lands in the next cycle
    a_open_write: assert property (@(posedge mclk) disable iff (!rst_n)
        s_open_write |=> regs_r[6] == $past(io_wdata))
        else $error("unlocked write lost");

    // start above end must hide the cursor whatever the row
    a_cursor_order: assert property (@(posedge mclk) disable iff (!rst_n)
        c_start > c_end |-> !cur_raw)
        else $error("cursor shown with start above end");

    // the cursor only appears at its own address
    a_cursor_addr: assert property (@(posedge mclk) disable iff (!rst_n)
        row_addr != ADDR_W'({regs_r[14], regs_r[15]}) |-> !cur_raw)
        else $error("cursor shown at wrong address");

    // zero skew passes the raw cursor after one character slot
    a_cursor_skew: assert property (@(posedge mclk) disable iff (!rst_n)
        s_char_noskew |=> cursor == $past(cur_raw))
        else $error("cursor skew wrong");
endmodule
